/* design/pwr_mon_consts.svh */
// register map, field positions and reset values of the power monitor
`ifndef PWR_MON_CONSTS_SVH
`define PWR_MON_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define PM_IDX_POWER_CONTROL   8'h87
`define PM_IDX_AUX_FUNCTION_1  8'ha2
`define PM_IDX_INT_ENABLE      8'hc0
`define PM_IDX_CONFIG_WORD_0   8'hc1
`define PM_IDX_IRQ_STATUS      8'hc2
`define PM_IDX_IRQ_MASK        8'hc3

// power_control_reg fields
`define PM_PC_POWER_ON_BIT     4
`define PM_PC_BROWNOUT_BIT     5
// aux_function_reg_1 fields
`define PM_AUX_BO_ENABLE_BIT   6
`define PM_AUX_BO_INTSEL_BIT   5
// interrupt_enable_register fields
`define PM_IE_GLOBAL_BIT       7
`define PM_IE_BROWNOUT_BIT     5
// config_word_0 fields
`define PM_CFG_LEVEL_LSB       3
`define PM_CFG_LEVEL_MSB       4

// reset values
`define PM_RST_POWER_CONTROL   8'h00
`define PM_RST_AUX_FUNCTION_1  8'h00
`define PM_RST_INT_ENABLE      8'h00
`define PM_RST_CONFIG_WORD_0   8'h10
`define PM_RST_IRQ             3'h0

// interrupt status bits
`define PM_EV_POWER_ON         0
`define PM_EV_BROWNOUT         1
`define PM_EV_BO_REQUEST       2

`endif

/* design/pwr_mon_pkg.sv */
// types shared by the power monitor design
package pwr_mon_pkg;

  typedef enum logic [1:0] {
    LEVEL_HIGH,
    LEVEL_MID,
    LEVEL_LOW
  } bo_level_t;

  typedef enum {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] index;
    logic       lane0;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic bo_request;
    logic brownout;
    logic power_on;
  } irq_events_t;

endpackage : pwr_mon_pkg

/* design/pwr_sync_2ff.sv */
// two-flop level synchroniser for asynchronous analog detector outputs
`timescale 1ns/1ps
`default_nettype none

module pwr_sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // ----------------------------------------------------------------
  // synchroniser stages
  // ----------------------------------------------------------------
  // the first stage feeds only the second; nothing else looks at it
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // pwr_sync_2ff

`default_nettype wire

/* design/power_on_brownout_monitor.sv */
// power-on and brownout monitor with its register block on avalon-mm
// Function
// - power-on detect sets power_on_flag, power_control bit 4, until software clears
// - level select 00 highest, 01 middle, 1x lowest; 1x after reset
// - detect indication holds while supply stays at or below selected level
// - detection acts only with brownout_enable set; it sets brownout_flag bit 5
// - brownout_flag raises reset or interrupt; only software clears it
// - interrupt_select chooses interrupt, gated by global and brownout enables
// - aux_function_reg_1 at a2h, enable bit 6, select bit 5, reset 0x00
`timescale 1ns/1ps
`default_nettype none
`include "pwr_mon_consts.svh"

module power_on_brownout_monitor
  import pwr_mon_pkg::*;
#(
  parameter int LEVELS = 3
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  // analog detector outputs, asynchronous
  input  wire logic              i_power_on_detect,
  input  wire logic [LEVELS-1:0] i_brownout_cmp,
  // avalon-mm slave
  input  wire logic [9:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // system side
  output logic                   o_brownout_detect,
  output logic                   o_brownout_reset,
  output logic                   o_brownout_irq,
  output logic                   o_irq
);

  // ----------------------------------------------------------------
  // register index decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == `PM_IDX_POWER_CONTROL)  || (idx == `PM_IDX_AUX_FUNCTION_1) ||
                (idx == `PM_IDX_INT_ENABLE)     || (idx == `PM_IDX_CONFIG_WORD_0)  ||
                (idx == `PM_IDX_IRQ_STATUS)     || (idx == `PM_IDX_IRQ_MASK);
  endfunction

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [LEVELS:0] async_in;
  logic [LEVELS:0] sync_in;

  assign async_in = {i_power_on_detect, i_brownout_cmp};

  pwr_sync_2ff #(
    .WIDTH (LEVELS + 1)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (async_in),
    .o_sync    (sync_in)
  );

  logic [LEVELS-1:0] cmp_sync;
  logic              por_sync;

  assign cmp_sync = sync_in[LEVELS-1:0];
  assign por_sync = sync_in[LEVELS];

  // ----------------------------------------------------------------
  // bus request and handshake
  // ----------------------------------------------------------------
  // every access is answered on the cycle after it is seen, so
  // waitrequest can come straight from a flop
  bus_req_t   req;
  bus_state_t bus_state_reg;
  bus_state_t bus_state_next;
  logic       wait_reg;
  logic       wait_next;
  logic       accept;
  logic       wr_hit;
  logic       req_new;

  assign req.read  = i_avs_read;
  assign req.write = i_avs_write;
  assign req.index = i_avs_address[9:2];
  assign req.lane0 = i_avs_byteenable[0];
  assign req.wdata = i_avs_writedata[7:0];

  assign req_new   = (req.read || req.write) && (bus_state_reg == BUS_IDLE);
  assign accept    = (req.read || req.write) && (bus_state_reg == BUS_ANSWER);
  assign wr_hit    = accept && req.write && req.lane0 && is_mapped(req.index);
  assign wait_next = (bus_state_next != BUS_ANSWER);

  // a request held past its answer is taken again as a new one: the answer cycle
  // always returns to idle, so the next request gets its own wait cycle
  always_comb begin
    case (bus_state_reg)
      BUS_IDLE: begin
        bus_state_next = req_new ? BUS_ANSWER : BUS_IDLE;
      end
      BUS_ANSWER: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_state_reg <= BUS_IDLE;
      wait_reg      <= 1'b1;
    end else begin
      bus_state_reg <= bus_state_next;
      wait_reg      <= wait_next;
    end
  end

  // per-register write strobes
  logic wr_pc;
  logic wr_aux;
  logic wr_ie;
  logic wr_cfg;
  logic wr_sts;
  logic wr_msk;

  assign wr_pc  = wr_hit && (req.index == `PM_IDX_POWER_CONTROL);
  assign wr_aux = wr_hit && (req.index == `PM_IDX_AUX_FUNCTION_1);
  assign wr_ie  = wr_hit && (req.index == `PM_IDX_INT_ENABLE);
  assign wr_cfg = wr_hit && (req.index == `PM_IDX_CONFIG_WORD_0);
  assign wr_sts = wr_hit && (req.index == `PM_IDX_IRQ_STATUS);
  assign wr_msk = wr_hit && (req.index == `PM_IDX_IRQ_MASK);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] aux_reg;
  logic [7:0] aux_next;
  logic [7:0] ie_reg;
  logic [7:0] ie_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;

  // the enable bit powers up undefined in silicon; here it resets to zero
  assign aux_next = wr_aux ? req.wdata : aux_reg;
  assign ie_next  = wr_ie  ? req.wdata : ie_reg;
  assign cfg_next = wr_cfg ? req.wdata : cfg_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aux_reg <= `PM_RST_AUX_FUNCTION_1;
      ie_reg  <= `PM_RST_INT_ENABLE;
      cfg_reg <= `PM_RST_CONFIG_WORD_0;
    end else begin
      aux_reg <= aux_next;
      ie_reg  <= ie_next;
      cfg_reg <= cfg_next;
    end
  end

  logic bo_enable;
  logic bo_int_select;
  logic global_int_en;
  logic bo_int_en;

  assign bo_enable     = aux_reg[`PM_AUX_BO_ENABLE_BIT];
  assign bo_int_select = aux_reg[`PM_AUX_BO_INTSEL_BIT];
  assign global_int_en = ie_reg[`PM_IE_GLOBAL_BIT];
  assign bo_int_en     = ie_reg[`PM_IE_BROWNOUT_BIT];

  // ----------------------------------------------------------------
  // trip level selection and detection
  // ----------------------------------------------------------------
  bo_level_t level_sel;
  logic      detect_level;
  logic      detect_reg;
  logic      detect_prev_reg;
  logic      active;
  logic      active_rise;

  // both 1x codes fall on the lowest level
  assign level_sel    = cfg_reg[`PM_CFG_LEVEL_MSB] ? LEVEL_LOW :
                        (cfg_reg[`PM_CFG_LEVEL_LSB] ? LEVEL_MID : LEVEL_HIGH);
  assign detect_level = cmp_sync[level_sel];
  assign active       = detect_reg && bo_enable;
  assign active_rise  = active && !detect_prev_reg;

  // detect_prev tracks the gated level so enabling during a dip counts once
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      detect_reg      <= 1'b0;
      detect_prev_reg <= 1'b0;
    end else begin
      detect_reg      <= detect_level;
      detect_prev_reg <= active;
    end
  end

  // ----------------------------------------------------------------
  // power control flags
  // ----------------------------------------------------------------
  logic [7:0] pc_reg;
  logic [7:0] pc_next;
  logic       por_prev_reg;
  logic       por_rise;
  logic       pof_clr;
  logic       bof_clr;
  logic       pof_next;
  logic       bof_next;
  logic [7:0] pc_plain;

  assign por_rise = por_sync && !por_prev_reg;
  // a flag is cleared by writing zero to it; a new event the same cycle wins
  assign pof_clr  = wr_pc && !req.wdata[`PM_PC_POWER_ON_BIT];
  assign bof_clr  = wr_pc && !req.wdata[`PM_PC_BROWNOUT_BIT];
  assign pof_next = por_rise || (pc_reg[`PM_PC_POWER_ON_BIT] && !pof_clr);
  assign bof_next = active   || (pc_reg[`PM_PC_BROWNOUT_BIT] && !bof_clr);
  assign pc_plain = wr_pc ? req.wdata : pc_reg;

  always_comb begin
    pc_next = pc_plain;
    pc_next[`PM_PC_POWER_ON_BIT] = pof_next;
    pc_next[`PM_PC_BROWNOUT_BIT] = bof_next;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_reg       <= `PM_RST_POWER_CONTROL;
      por_prev_reg <= 1'b0;
    end else begin
      pc_reg       <= pc_next;
      por_prev_reg <= por_sync;
    end
  end

  logic bo_flag;

  assign bo_flag = pc_reg[`PM_PC_BROWNOUT_BIT];

  // ----------------------------------------------------------------
  // brownout action
  // ----------------------------------------------------------------
  logic rst_req_next;
  logic irq_req_next;
  logic bo_req_rise;
  logic bo_irq_reg;

  // limitation: the reset request ends when software clears the flag
  assign rst_req_next = bo_flag && !bo_int_select;
  assign irq_req_next = bo_flag && bo_int_select && global_int_en && bo_int_en;
  assign bo_req_rise  = irq_req_next && !bo_irq_reg;

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  irq_events_t ev;
  logic [2:0]  sts_reg;
  logic [2:0]  sts_next;
  logic [2:0]  msk_reg;
  logic [2:0]  msk_next;
  logic [2:0]  sts_clr;

  assign ev.power_on   = por_rise;
  assign ev.brownout   = active_rise;
  assign ev.bo_request = bo_req_rise;
  assign sts_clr  = wr_sts ? req.wdata[2:0] : 3'h0;
  // per bit: a new event wins over a write-one-to-clear in the same cycle
  for (genvar g = 0; g < 3; g++) begin : g_sts
    assign sts_next[g] = ev[g] || (sts_reg[g] && !sts_clr[g]);
  end
  assign msk_next = wr_msk ? req.wdata[2:0] : msk_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sts_reg <= `PM_RST_IRQ;
      msk_reg <= `PM_RST_IRQ;
    end else begin
      sts_reg <= sts_next;
      msk_reg <= msk_next;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0]  rd_byte;
  logic        rd_take;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  assign rd_byte =
    (req.index == `PM_IDX_POWER_CONTROL)  ? pc_reg  :
    (req.index == `PM_IDX_AUX_FUNCTION_1) ? aux_reg :
    (req.index == `PM_IDX_INT_ENABLE)     ? ie_reg  :
    (req.index == `PM_IDX_CONFIG_WORD_0)  ? cfg_reg :
    (req.index == `PM_IDX_IRQ_STATUS)     ? {5'h00, sts_reg} :
    (req.index == `PM_IDX_IRQ_MASK)       ? {5'h00, msk_reg} : 8'h00;

  // captured as the request is first seen and dropped after its answer
  // cycle, so the bus shows zero whenever waitrequest is high
  assign rd_take    = req.read && req_new && is_mapped(req.index);
  assign rdata_next = rd_take ? {24'h000000, rd_byte} : 32'h00000000;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  logic det_out_reg;
  logic bo_rst_reg;
  logic irq_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      det_out_reg <= 1'b0;
      bo_rst_reg  <= 1'b0;
      bo_irq_reg  <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      det_out_reg <= detect_reg;
      bo_rst_reg  <= rst_req_next;
      bo_irq_reg  <= irq_req_next;
      irq_reg     <= |(sts_next & msk_next);
    end
  end

  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_brownout_detect = det_out_reg;
  assign o_brownout_reset  = bo_rst_reg;
  assign o_brownout_irq    = bo_irq_reg;
  assign o_irq             = irq_reg;

endmodule // power_on_brownout_monitor

`default_nettype wire

/* testbench/power_on_brownout_monitor_checker.sv */
// port-level assertions for the power monitor
`timescale 1ns/1ps
`default_nettype none

module power_on_brownout_monitor_checker #(
  parameter int LEVELS = 3
) (
  input wire logic              i_ref_clk,
  input wire logic              i_rst_n,
  input wire logic              i_power_on_detect,
  input wire logic [LEVELS-1:0] i_brownout_cmp,
  input wire logic [9:0]        i_avs_address,
  input wire logic              i_avs_read,
  input wire logic              i_avs_write,
  input wire logic [31:0]       i_avs_writedata,
  input wire logic [3:0]        i_avs_byteenable,
  input wire logic [31:0]       o_avs_readdata,
  input wire logic              o_avs_waitrequest,
  input wire logic              o_brownout_detect,
  input wire logic              o_brownout_reset,
  input wire logic              o_brownout_irq,
  input wire logic              o_irq
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_answer;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |-> ##[1:2] !o_avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("no bus answer");
  property p_one_cycle;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("answer too long");
  property p_idle_data;
    o_avs_waitrequest |-> o_avs_readdata == 32'h0;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data outside answer");
  // all comparators agree, so the outcome holds whatever level is selected
  property p_det_low;
    (i_brownout_cmp == '0) [*5] |=> !o_brownout_detect;
  endproperty
  a_det_low: assert property (p_det_low) else $error("detect without dip");
  property p_det_high;
    (i_brownout_cmp == {LEVELS{1'b1}}) [*5] |=> o_brownout_detect;
  endproperty
  a_det_high: assert property (p_det_high) else $error("dip not detected");
  property p_excl;
    !(o_brownout_reset && o_brownout_irq);
  endproperty
  a_excl: assert property (p_excl) else $error("reset and irq together");
  // writes may clear flags or change selection, so they are left out
  property p_rst_hold;
    o_brownout_reset && !i_avs_write && !$past(i_avs_write) && !$past(i_avs_write, 2)
      |=> o_brownout_reset;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset request dropped");
  property p_irq_hold;
    o_irq && !i_avs_write && !$past(i_avs_write) && !$past(i_avs_write, 2) |=> o_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_needs_det;
    $rose(o_brownout_reset) && !$past(i_avs_write) && !$past(i_avs_write, 2)
      |-> o_brownout_detect || $past(o_brownout_detect);
  endproperty
  a_needs_det: assert property (p_needs_det) else $error("reset without dip");
endmodule // power_on_brownout_monitor_checker

bind power_on_brownout_monitor power_on_brownout_monitor_checker #(.LEVELS(LEVELS)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_power_on_detect(i_power_on_detect),
  .i_brownout_cmp(i_brownout_cmp), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_brownout_detect(o_brownout_detect),
  .o_brownout_reset(o_brownout_reset), .o_brownout_irq(o_brownout_irq), .o_irq(o_irq));

`default_nettype wire

/* testbench/power_on_brownout_monitor_tb_top.sv */
// self-checking bench for the power monitor
`timescale 1ns/1ps
`default_nettype none
`include "pwr_mon_consts.svh"

module power_on_brownout_monitor_tb_top;
  localparam logic [7:0] PC = `PM_IDX_POWER_CONTROL;
  localparam logic [7:0] AUX = `PM_IDX_AUX_FUNCTION_1;
  localparam logic [7:0] IE = `PM_IDX_INT_ENABLE;
  localparam logic [7:0] CFG = `PM_IDX_CONFIG_WORD_0;
  localparam logic [7:0] ST = `PM_IDX_IRQ_STATUS;
  localparam logic [7:0] MSK = `PM_IDX_IRQ_MASK;
  typedef struct packed {
    logic [3:0] be;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        pod = 1'b0;
  logic [2:0]  cmp = 3'h0;
  logic [9:0]  adr = 10'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'h0;
  logic [31:0] rdat;
  logic        wait_req;
  logic        bo_det;
  logic        bo_rst;
  logic        bo_irq;
  logic        irq;
  logic [31:0] r;
  int          mismatches = 0;
  int          n_checks = 0;
  int          sel;
  row_t        rows [11];

  always #2.5 clk = ~clk;

  power_on_brownout_monitor #(.LEVELS(3)) u_dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_power_on_detect(pod), .i_brownout_cmp(cmp),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_req),
    .o_brownout_detect(bo_det), .o_brownout_reset(bo_rst), .o_brownout_irq(bo_irq),
    .o_irq(irq));

  // ----
  // tasks
  // ----
  task automatic final_report();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // an idle edge first, so a release and a new request never share a step
  task automatic bus(input logic w, input logic [3:0] b, input logic [7:0] i,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {i, 2'b00};
    wr <= w;
    rd <= !w;
    be <= b;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, 4'h1, i, d, q);
  endtask
  task automatic rreg(input logic [7:0] i, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, 4'h1, i, 8'h00, q);
    chk32(q, exp);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end

  // ----
  // main sequence
  // ----
  initial begin
    rows = '{'{4'h0, PC, 8'hff, 8'h00}, '{4'h0, AUX, 8'hff, 8'h00},
             '{4'h0, IE, 8'hff, 8'h00}, '{4'h0, CFG, 8'hff, 8'h10},
             '{4'h0, ST, 8'hff, 8'h00}, '{4'h0, MSK, 8'hff, 8'h00},
             '{4'h1, AUX, 8'h60, 8'h60}, '{4'h1, AUX, 8'h00, 8'h00},
             '{4'h1, PC, 8'h0f, 8'h0f}, '{4'h1, PC, 8'h00, 8'h00},
             '{4'h1, 8'h10, 8'hff, 8'h00}};
    wait_clk(8);
    chk1(wait_req, 1'b1);
    chk1(bo_rst | bo_irq | irq | bo_det, 1'b0);
    rst_n <= 1'b1;
    foreach (rows[k]) begin
      bus(1'b1, rows[k].be, rows[k].idx, rows[k].wd, r);
      rreg(rows[k].idx, {24'h0, rows[k].exp});
    end
    pod <= 1'b1;
    wait_clk(8);
    rreg(PC, 32'h10);
    pod <= 1'b0;
    wreg(PC, 8'h10);
    rreg(PC, 32'h10);
    wreg(PC, 8'h00);
    rreg(PC, 32'h00);
    chk1(irq, 1'b0);
    wreg(MSK, 8'h01);
    wait_clk(2);
    chk1(irq, 1'b1);
    wreg(ST, 8'h01);
    wait_clk(2);
    chk1(irq, 1'b0);
    // detection disabled here, so the flag must stay clear
    for (int c = 0; c < 4; c++) begin
      sel = (c > 1) ? 2 : c;
      wreg(CFG, 8'(c << 3));
      cmp <= 3'(1 << sel);
      wait_clk(8);
      chk1(bo_det, 1'b1);
      cmp <= 3'h7 ^ 3'(1 << sel);
      wait_clk(8);
      chk1(bo_det, 1'b0);
    end
    rreg(PC, 32'h00);
    wreg(AUX, 8'h40);
    cmp <= 3'h7;
    wait_clk(8);
    chk1(bo_rst, 1'b1);
    chk1(bo_irq, 1'b0);
    wreg(PC, 8'h00);
    rreg(PC, 32'h20);
    cmp <= 3'h0;
    wait_clk(8);
    chk1(bo_det, 1'b0);
    chk1(bo_rst, 1'b1);
    wreg(PC, 8'h00);
    wait_clk(2);
    chk1(bo_rst, 1'b0);
    wreg(ST, 8'hff);
    wreg(AUX, 8'h60);
    wreg(IE, 8'h20);
    cmp <= 3'h7;
    wait_clk(8);
    chk1(bo_irq, 1'b0);
    chk1(bo_rst, 1'b0);
    wreg(IE, 8'ha0);
    wait_clk(2);
    chk1(bo_irq, 1'b1);
    wreg(IE, 8'h80);
    wait_clk(2);
    chk1(bo_irq, 1'b0);
    rreg(ST, 32'h06);
    wreg(MSK, 8'h02);
    wait_clk(2);
    chk1(irq, 1'b1);
    cmp <= 3'h0;
    wait_clk(8);
    wreg(PC, 8'h00);
    wreg(ST, 8'hff);
    wait_clk(2);
    chk1(irq, 1'b0);
    rst_n <= 1'b0;
    wait_clk(2);
    chk1(wait_req, 1'b1);
    rst_n <= 1'b1;
    rreg(AUX, 32'h00);
    rreg(CFG, 32'h10);
    final_report();
  end
endmodule // power_on_brownout_monitor_tb_top

`default_nettype wire
